// ==== include/rtcs_pkg.sv ====
package rtcs_pkg;

    // ------------------------------------------------------------------
    // Clock and link timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 25;
    localparam int T_SETUP_NS     = 31000;
    localparam int T_GAP_NS       = 61000;
    localparam int T_CE_MAX_NS    = 1000000000;
    localparam int SETUP_CYC      = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC        = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CE_MAX_CYC     = T_CE_MAX_NS / CLK_PERIOD_NS;
    localparam int HALF_CYC       = 4;
    localparam int CNT_W          = 26;

    // ------------------------------------------------------------------
    // Serial protocol
    // ------------------------------------------------------------------
    localparam int BYTE_W         = 8;
    localparam logic [3:0] FMT_WR_SINGLE = 4'h8;
    localparam logic [3:0] FMT_WR_BURST  = 4'h0;
    localparam logic [3:0] FMT_RD_SINGLE = 4'hc;
    localparam logic [3:0] FMT_RD_BURST  = 4'h4;
    localparam int FMT_READ_BIT   = 2;
    localparam int FMT_SINGLE_BIT = 3;
    localparam logic [3:0] DET_REG_ADDR  = 4'hf;
    localparam int POWER_LOSS_BIT = 4;
    localparam int OSC_RUN_BIT    = 5;
    localparam int SUPPLY_DROP_BIT = 6;

    // ------------------------------------------------------------------
    // Controller register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_TXDATA = 8'h04;
    localparam logic [7:0] OFS_RXDATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam int CTRL_GO        = 0;
    localparam int CTRL_LAST      = 1;
    localparam int CTRL_STOP      = 2;
    localparam int CTRL_IDLE_HI   = 3;
    localparam int ST_BUSY        = 0;
    localparam int ST_CE          = 1;
    localparam int ST_TIMEOUT     = 2;
    localparam int ST_BAD_FMT     = 3;
    localparam int ST_PTR_LSB     = 4;
    localparam int ST_FMT_LSB     = 8;
    localparam int ST_FLAGS_VALID = 12;
    localparam int ST_POWER_LOSS  = 13;
    localparam int ST_OSC_RUN     = 14;
    localparam int ST_SUPPLY_DROP = 15;
    localparam int ST_NEED_INIT   = 16;

    typedef struct packed {
        logic              idle_hi;
        logic [BYTE_W-1:0] data;
    } rtcs_shreq_t;

    typedef struct packed {
        logic power_loss;
        logic osc_running;
        logic supply_drop;
    } rtcs_flags_t;

endpackage

// ==== hw/rtcs_shift.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcs_shift
    import rtcs_pkg::*;
#(
    parameter int HALF = HALF_CYC
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic              idle_hi_i,
    input  wire logic              start_i,
    input  wire logic              abort_i,
    input  wire rtcs_shreq_t       req_i,
    input  wire logic              do_i,
    output logic                   sclk_o,
    output logic                   di_o,
    output logic                   busy_o,
    output logic                   done_o,
    output logic [BYTE_W-1:0]      rx_o
);

    logic [7:0]        cnt_r;
    logic [2:0]        bit_r;
    logic              phase_r;
    logic [BYTE_W-1:0] tx_r;

    // ------------------------------------------------------------------
    // Bit engine
    // ------------------------------------------------------------------
    // Each bit leaves the idle level first and returns to it second. The
    // device drives its output on the leaving edge and captures ours on
    // the returning edge in both modes, so one sequence serves both.
    always_ff @(posedge mclk_i) begin
        done_o <= 1'b0;
        if (!rst_n_i) begin
            cnt_r   <= 8'h00;
            bit_r   <= 3'h0;
            phase_r <= 1'b0;
            tx_r    <= 8'h00;
            sclk_o  <= 1'b0;
            di_o    <= 1'b0;
            busy_o  <= 1'b0;
            rx_o    <= 8'h00;
        end else if (abort_i) begin
            busy_o <= 1'b0;
            sclk_o <= idle_hi_i;
            di_o   <= 1'b0;
        end else if (!busy_o) begin
            sclk_o <= idle_hi_i;
            if (start_i) begin
                busy_o  <= 1'b1;
                bit_r   <= 3'h7;
                phase_r <= 1'b0;
                cnt_r   <= 8'h00;
                tx_r    <= req_i.data;
                di_o    <= req_i.data[7];
                sclk_o  <= ~req_i.idle_hi;
            end
        end else if (cnt_r == 8'(HALF - 1)) begin
            cnt_r <= 8'h00;
            if (!phase_r) begin
                rx_o    <= {rx_o[6:0], do_i};
                sclk_o  <= idle_hi_i;
                phase_r <= 1'b1;
            end else if (bit_r == 3'h0) begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
                di_o   <= 1'b0;
            end else begin
                bit_r   <= bit_r - 3'h1;
                tx_r    <= {tx_r[6:0], 1'b0};
                di_o    <= tx_r[6];
                sclk_o  <= ~idle_hi_i;
                phase_r <= 1'b0;
            end
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

endmodule
`default_nettype wire

// ==== hw/rtcs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcs_host
    import rtcs_pkg::*;
#(
    parameter int CE_MAX = CE_MAX_CYC,
    parameter int HALF   = HALF_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    output logic             ce_o,
    output logic             sclk_o,
    output logic             serial_in_o,
    input  wire logic        serial_out_i
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_GAP, ST_SETUP, ST_SHIFT, ST_OPEN
    } rtcs_state_t;

    rtcs_state_t       state_r;
    logic              do_s1_r;
    logic              do_s2_r;
    logic              wr_pend_r;
    logic [7:0]        waddr_r;
    logic              go_r;
    logic              stop_r;
    logic              last_r;
    logic              last_arm_r;
    logic              idle_hi_r;
    logic [BYTE_W-1:0] txdata_r;
    logic [BYTE_W-1:0] rxdata_r;
    logic              timeout_r;
    logic [CNT_W-1:0]  hi_cnt_r;
    logic [CNT_W-1:0]  low_cnt_r;
    logic              sh_start_r;
    logic              sh_abort_r;
    rtcs_shreq_t       sh_req_r;
    logic              sh_busy;
    logic              sh_done;
    logic [BYTE_W-1:0] sh_rx;
    logic              hdr_pend_r;
    logic              byte_hdr_r;
    logic [3:0]        ptr_r;
    logic [3:0]        fmt_r;
    rtcs_flags_t       flags_r;
    logic              flags_valid_r;
    logic              timeout_hit;
    logic              accept;
    logic [31:0]       status;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            do_s1_r <= 1'b0;
            do_s2_r <= 1'b0;
        end else begin
            do_s1_r <= serial_out_i;
            do_s2_r <= do_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    assign accept = hsel_i && htrans_i[1] && hready_i;

    always_comb begin
        status = 32'h0000_0000;
        status[ST_BUSY]        = (state_r != ST_IDLE) && (state_r != ST_OPEN);
        status[ST_CE]          = ce_o;
        status[ST_TIMEOUT]     = timeout_r;
        status[ST_BAD_FMT]     = (fmt_r[1:0] != 2'b00);
        status[ST_PTR_LSB+:4]  = ptr_r;
        status[ST_FMT_LSB+:4]  = fmt_r;
        status[ST_FLAGS_VALID] = flags_valid_r;
        status[ST_POWER_LOSS]  = flags_r.power_loss;
        status[ST_OSC_RUN]     = flags_r.osc_running;
        status[ST_SUPPLY_DROP] = flags_r.supply_drop;
        status[ST_NEED_INIT]   = flags_valid_r
                                 && (flags_r.power_loss
                                     || !flags_r.osc_running);
    end

    // Zero wait states: the read word is registered in the address phase.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            hrdata_o    <= 32'h0000_0000;
            wr_pend_r   <= 1'b0;
            waddr_r     <= 8'h00;
        end else begin
            wr_pend_r <= accept && hwrite_i;
            if (accept) begin
                waddr_r <= haddr_i[7:0];
            end
            if (accept && !hwrite_i) begin
                unique case (haddr_i[7:0])
                    OFS_CTRL:   hrdata_o <= {28'h0, idle_hi_r, 3'h0};
                    OFS_TXDATA: hrdata_o <= {24'h0, txdata_r};
                    OFS_RXDATA: hrdata_o <= {24'h0, rxdata_r};
                    OFS_STATUS: hrdata_o <= status;
                    default:    hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            go_r      <= 1'b0;
            stop_r    <= 1'b0;
            last_r    <= 1'b0;
            idle_hi_r <= 1'b0;
            txdata_r  <= 8'h00;
        end else begin
            go_r   <= 1'b0;
            stop_r <= 1'b0;
            if (wr_pend_r && waddr_r == OFS_CTRL) begin
                go_r   <= hwdata_i[CTRL_GO];
                stop_r <= hwdata_i[CTRL_STOP];
                last_r <= hwdata_i[CTRL_LAST];
                // Clock mode may only change while enable is low.
                if (!ce_o) begin
                    idle_hi_r <= hwdata_i[CTRL_IDLE_HI];
                end
            end
            if (wr_pend_r && waddr_r == OFS_TXDATA) begin
                txdata_r <= hwdata_i[7:0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            timeout_r <= 1'b0;
        end else if (timeout_hit) begin
            timeout_r <= 1'b1;
        end else if (wr_pend_r && waddr_r == OFS_STATUS
                     && hwdata_i[ST_TIMEOUT]) begin
            timeout_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Enable timing
    // ------------------------------------------------------------------
    assign timeout_hit = ce_o && (hi_cnt_r == CNT_W'(CE_MAX - 1));

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hi_cnt_r  <= '0;
            low_cnt_r <= '0;
        end else if (ce_o) begin
            hi_cnt_r  <= hi_cnt_r + CNT_W'(1);
            low_cnt_r <= '0;
        end else begin
            hi_cnt_r <= '0;
            if (low_cnt_r < CNT_W'(GAP_CYC)) begin
                low_cnt_r <= low_cnt_r + CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    // Software issues one byte per go; the byte after an enable rise and
    // after each single-byte data byte is taken as a header, so the read
    // direction follows from the format the host itself sent.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r    <= ST_IDLE;
            ce_o       <= 1'b0;
            sh_start_r <= 1'b0;
            sh_abort_r <= 1'b0;
            sh_req_r   <= '0;
            last_arm_r <= 1'b0;
            byte_hdr_r <= 1'b0;
        end else begin
            sh_start_r <= 1'b0;
            sh_abort_r <= 1'b0;
            if (timeout_hit) begin
                ce_o       <= 1'b0;
                sh_abort_r <= 1'b1;
                state_r    <= ST_IDLE;
            end else begin
                unique case (state_r)
                    ST_IDLE: begin
                        if (go_r) begin
                            last_arm_r <= last_r;
                            state_r    <= ST_GAP;
                        end
                    end
                    ST_GAP: begin
                        if (low_cnt_r >= CNT_W'(GAP_CYC)) begin
                            ce_o    <= 1'b1;
                            state_r <= ST_SETUP;
                        end
                    end
                    ST_SETUP: begin
                        if (hi_cnt_r >= CNT_W'(SETUP_CYC)) begin
                            sh_start_r       <= 1'b1;
                            sh_req_r.idle_hi <= idle_hi_r;
                            sh_req_r.data    <= txdata_r;
                            byte_hdr_r       <= 1'b1;
                            state_r          <= ST_SHIFT;
                        end
                    end
                    ST_SHIFT: begin
                        if (sh_done) begin
                            if (last_arm_r) begin
                                ce_o    <= 1'b0;
                                state_r <= ST_IDLE;
                            end else begin
                                state_r <= ST_OPEN;
                            end
                        end
                    end
                    ST_OPEN: begin
                        if (stop_r) begin
                            ce_o    <= 1'b0;
                            state_r <= ST_IDLE;
                        end else if (go_r) begin
                            last_arm_r       <= last_r;
                            sh_start_r       <= 1'b1;
                            sh_req_r.idle_hi <= idle_hi_r;
                            byte_hdr_r       <= hdr_pend_r;
                            // Read bytes send zeros while the device drives.
                            sh_req_r.data    <= (!hdr_pend_r
                                                 && fmt_r[FMT_READ_BIT])
                                                ? 8'h00 : txdata_r;
                            state_r          <= ST_SHIFT;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Header and pointer tracking
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hdr_pend_r    <= 1'b1;
            ptr_r         <= 4'h0;
            fmt_r         <= 4'h0;
            rxdata_r      <= 8'h00;
            flags_r       <= '0;
            flags_valid_r <= 1'b0;
        end else if (!ce_o) begin
            hdr_pend_r <= 1'b1;
        end else if (sh_done) begin
            if (byte_hdr_r) begin
                ptr_r      <= sh_req_r.data[7:4];
                fmt_r      <= sh_req_r.data[3:0];
                hdr_pend_r <= 1'b0;
            end else begin
                if (fmt_r[FMT_READ_BIT]) begin
                    rxdata_r <= sh_rx;
                    if (ptr_r == DET_REG_ADDR) begin
                        flags_r.power_loss  <= sh_rx[POWER_LOSS_BIT];
                        flags_r.osc_running <= sh_rx[OSC_RUN_BIT];
                        flags_r.supply_drop <= sh_rx[SUPPLY_DROP_BIT];
                        flags_valid_r       <= 1'b1;
                    end
                end
                if (fmt_r[FMT_SINGLE_BIT]) begin
                    hdr_pend_r <= 1'b1;
                end else begin
                    ptr_r <= ptr_r + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------------
    rtcs_shift #(
        .HALF(HALF)
    ) u_shift (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .idle_hi_i (idle_hi_r),
        .start_i   (sh_start_r),
        .abort_i   (sh_abort_r),
        .req_i     (sh_req_r),
        .do_i      (do_s2_r),
        .sclk_o    (sclk_o),
        .di_o      (serial_in_o),
        .busy_o    (sh_busy),
        .done_o    (sh_done),
        .rx_o      (sh_rx)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_enable_gap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(ce_o) |-> $past(low_cnt_r) >= CNT_W'(GAP_CYC))
        else $error("enable raised before the low gap elapsed");

    chk_setup_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (sh_start_r && $past(state_r == ST_SETUP))
        |-> hi_cnt_r > CNT_W'(SETUP_CYC))
        else $error("first byte started before the setup wait");

    chk_enable_max: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ce_o |-> hi_cnt_r < CNT_W'(CE_MAX))
        else $error("enable stayed high too long");

    chk_mode_at_rise: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(ce_o) |-> sclk_o == idle_hi_r && $stable(sclk_o))
        else $error("serial clock not at its idle level at enable rise");

    chk_mode_stable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ce_o && $past(ce_o)) |-> $stable(idle_hi_r))
        else $error("clock mode changed inside a transfer");

    chk_no_clk_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !ce_o ##1 (!ce_o && $stable(idle_hi_r))
        |-> !sh_busy && sclk_o == idle_hi_r)
        else $error("serial clock moved while enable is low");

    chk_burst_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ce_o && sh_done && !byte_hdr_r && !fmt_r[FMT_SINGLE_BIT]
         && ptr_r == 4'hf) |=> ptr_r == 4'h0)
        else $error("burst pointer did not wrap to zero");

    chk_single_rehdr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ce_o && sh_done && !byte_hdr_r && fmt_r[FMT_SINGLE_BIT])
        |=> hdr_pend_r && $stable(ptr_r))
        else $error("single byte not followed by a new header");

    chk_read_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (sh_busy && !byte_hdr_r && fmt_r[FMT_READ_BIT]) |-> !serial_in_o)
        else $error("host data line active during a read byte");

    chk_flag_latch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (ce_o && sh_done && !byte_hdr_r && fmt_r[FMT_READ_BIT]
         && ptr_r == DET_REG_ADDR)
        |=> flags_r.osc_running == $past(sh_rx[OSC_RUN_BIT]))
        else $error("detection flags not captured from register Fh");

    cov_single_write: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        sh_done && !byte_hdr_r && fmt_r == FMT_WR_SINGLE);
    cov_burst_read: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        sh_done && !byte_hdr_r && fmt_r == FMT_RD_BURST && ptr_r == 4'hf);
    cov_burst_write: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        sh_done && !byte_hdr_r && fmt_r == FMT_WR_BURST);
    cov_timeout: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        timeout_hit);

endmodule
`default_nettype wire

// ==== sim/rtcs_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtcs_dev_model (
    input  wire logic ce_i,
    input  wire logic sclk_i,
    input  wire logic serial_in_i,
    output logic      dout_o
);
    logic [7:0] mem [16];
    logic [7:0] sh;
    logic [3:0] ptr;
    logic [3:0] fmt;
    logic       mode;
    logic       hdr;
    int         n;
    // ------------------------------------------------------------------
    // Behavioural clock device
    // ------------------------------------------------------------------
    initial begin
        mem = '{default: 8'h00};
        mem[15] = 8'h30;
        dout_o = 1'b0;
    end
    always @(posedge ce_i) begin
        mode = sclk_i;
        hdr = 1'b1;
        n = 0;
    end
    // A released output toggles so that a stale bit never looks valid.
    always @(negedge ce_i) dout_o = ~dout_o;
    always @(sclk_i) begin
        if (ce_i && sclk_i !== mode) begin
            if (!hdr && fmt[2]) dout_o = mem[ptr][7-n];
            else dout_o = ~dout_o;
        end else if (ce_i) begin
            sh = {sh[6:0], serial_in_i};
            n = n + 1;
            if (n == 8) begin
                n = 0;
                if (hdr) {ptr, fmt} = sh;
                else begin
                    if (!fmt[2] && ptr == 4'hf)
                        mem[ptr] = {sh[7], sh[6] & mem[ptr][6],
                                    sh[5] | mem[ptr][5],
                                    sh[4] & mem[ptr][4], sh[3:0]};
                    else if (!fmt[2]) mem[ptr] = sh;
                    ptr = ptr + 4'h1;
                end
                hdr = hdr ? 1'b0 : fmt[3];
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
    import rtcs_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        ce;
    logic        sclk;
    logic        sdi;
    logic        sdo;
    logic        idle = 1'b0;
    int          mismatches = 0;
    int          checked = 0;
    always #12.5 mclk = ~mclk;
    rtcs_host #(.CE_MAX(5000)) u_rtcs_host (.mclk_i(mclk), .rst_n_i(rst_n),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .ce_o(ce), .sclk_o(sclk), .serial_in_o(sdi),
        .serial_out_i(sdo));
    rtcs_dev_model u_rtcs_dev_model (.ce_i(ce), .sclk_i(sclk),
        .serial_in_i(sdi), .dout_o(sdo));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Polling stops after 9000 status reads so a stuck sequencer cannot hang the task; running out records no mismatch.
    task automatic xfer(input logic [7:0] b, input logic lst);
        logic [31:0] r;
        bus(1'b1, OFS_TXDATA, {24'h0, b}, r);
        bus(1'b1, OFS_CTRL, {28'h0, idle, 1'b0, lst, 1'b1}, r);
        // The sequencer leaves idle or open on the first edge after the write lands.
        repeat (2) @(posedge mclk);
        r = 32'h1;
        for (int i = 0; i < 9000 && r[ST_BUSY] !== 1'b0; i++)
            bus(1'b0, OFS_STATUS, 32'h0, r);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic t_flags;
        xfer(8'hfc, 1'b0);
        xfer(8'h00, 1'b1);
        rd_chk("rxdata", OFS_RXDATA, 32'h30);
        rd_chk("status", OFS_STATUS, 32'h0001_7cf0);
        rd_chk("unmapped", 8'h10, 32'h0);
    endtask
    task automatic t_chain;
        xfer(8'hf8, 1'b0);
        xfer(8'h20, 1'b0);
        xfer(8'hfc, 1'b0);
        xfer(8'h00, 1'b1);
        rd_chk("rxdata", OFS_RXDATA, 32'h20);
        rd_chk("status", OFS_STATUS, 32'h0000_5cf0);
    endtask
    task automatic t_burst;
        idle = 1'b1;
        xfer(8'he0, 1'b0);
        xfer(8'h5a, 1'b0);
        xfer(8'h20, 1'b0);
        xfer(8'ha5, 1'b1);
        xfer(8'he4, 1'b0);
        xfer(8'h00, 1'b0);
        rd_chk("burst_e", OFS_RXDATA, 32'h5a);
        xfer(8'h00, 1'b0);
        rd_chk("burst_f", OFS_RXDATA, 32'h20);
        xfer(8'h00, 1'b1);
        rd_chk("burst_0", OFS_RXDATA, 32'ha5);
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_flags();
        t_chain();
        t_burst();
        results();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
